// ===== enc_defs.svh
`ifndef ENC_DEFS_SVH
`define ENC_DEFS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define A_CTRL 12'h000
`define A_FAULT 12'h004
`define A_STATE 12'h008
`define A_POS 12'h00C
`define A_PRESET 12'h010
// ----------------------------------------
// register select bits
// ----------------------------------------
`define R_CTRL 0
`define R_FAULT 1
`define R_STATE 2
`define R_POS 3
`define R_PRESET 4
// ----------------------------------------
// field positions
// ----------------------------------------
`define B_INV 0
`define B_PRESET_EN 1
`define B_SENS_ST 0
`define B_SENS_MT 1
`define B_LIGHT 2
`define B_TEMP 3
`define B_DIRCHG 4
// ----------------------------------------
// times (ms) and cycle counts at 100 MHz
// ----------------------------------------
`define CLK_KHZ 100000
`define T_MIN_PULSE_MS 10
`define T_DELAY_MS 1
`define T_PROC_MS 15
`define T_PWRON_MS 150
`define DIR_REACT_MS 1
`endif

// ===== enc_pkg.sv
package enc_pkg;
   typedef enum logic [1:0] {ST_PWRON, ST_RUN, ST_PROC} mode_t;
   typedef struct packed {
      logic sens_st;
      logic sens_mt;
      logic light;
      logic temp;
   } fault_in_t;
   typedef struct packed {
      logic status_o;
      logic status_oe;
      logic led_on;
      logic pos_valid;
   } stat_out_t;
endpackage

// ===== encoder_preset_dir_status.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "enc_defs.svh"
module encoder_preset_dir_status #(
   parameter int PWRON_CYC = `T_PWRON_MS * `CLK_KHZ,
   parameter int PROC_CYC = `T_PROC_MS * `CLK_KHZ,
   parameter int PRE_CYC = `T_DELAY_MS * `CLK_KHZ,
   parameter int DIR_CYC = `DIR_REACT_MS * `CLK_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic preset_pin,
   input wire logic preset_key,
   input wire logic dir_pin,
   input wire logic step,
   input wire enc_pkg::fault_in_t fault_in,
   output enc_pkg::stat_out_t stat_out
);
   import enc_pkg::*;

   // ----------------------------------------
   // input synchronisers, three stages
   // ----------------------------------------
   logic [2:0] s1_q, s2_q, s3_q;
   logic [2:0] raw;
   assign raw = {dir_pin, preset_key, preset_pin};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // filters: a level counts once stable for the count
   // ----------------------------------------
   logic [24:0] pcnt_q, pcnt_d, dcnt_q, dcnt_d;
   logic pflt_q, pflt_d, dflt_q, dflt_d;
   logic pstable, dstable, pboth;
   assign pstable = s2_q[0] == s3_q[0] && s2_q[1] == s3_q[1];
   assign dstable = s2_q[2] == s3_q[2];
   assign pboth = s3_q[0] | s3_q[1];
   // the 1 ms filter also screens short pulses; holding the
   // preset for the full 10 ms is left to the controller
   always_comb begin
      pcnt_d = pcnt_q;
      pflt_d = pflt_q;
      dcnt_d = dcnt_q;
      dflt_d = dflt_q;
      // short pulses never reach the count
      if (!pstable || pboth == pflt_q) begin
         pcnt_d = 25'h0;
      end else if (pcnt_q >= 25'(PRE_CYC - 1)) begin
         pcnt_d = 25'h0;
         pflt_d = pboth;
      end else begin
         pcnt_d = pcnt_q + 25'h1;
      end
      if (!dstable || s3_q[2] == dflt_q) begin
         dcnt_d = 25'h0;
      end else if (dcnt_q >= 25'(DIR_CYC - 1)) begin
         dcnt_d = 25'h0;
         dflt_d = s3_q[2];
      end else begin
         dcnt_d = dcnt_q + 25'h1;
      end
   end

   // ----------------------------------------
   // mode, timers, position, faults
   // ----------------------------------------
   mode_t mode_q, mode_d;
   logic [27:0] tmr_q, tmr_d;
   logic [28:0] pos_q, pos_d;
   logic [28:0] preset_val_q, preset_val_d;
   logic [1:0] cfg_q, cfg_d;
   logic [4:0] fault_q, fault_d;
   logic dir_ref_q, dir_ref_d;
   logic prise, ccw;
   assign prise = pflt_d & ~pflt_q;
   // inversion option flips the input sense
   assign ccw = dflt_q ^ cfg_q[`B_INV];

   // a preset during power-on or processing is ignored on purpose;
   // the controller must wait out both before reading
   always_comb begin
      mode_d = mode_q;
      tmr_d = tmr_q;
      pos_d = pos_q;
      dir_ref_d = dir_ref_q;
      // faults only ever set; no clear path
      fault_d = fault_q;
      fault_d[`B_SENS_ST] = fault_q[`B_SENS_ST] | fault_in.sens_st;
      fault_d[`B_SENS_MT] = fault_q[`B_SENS_MT] | fault_in.sens_mt;
      fault_d[`B_LIGHT] = fault_q[`B_LIGHT] | fault_in.light;
      fault_d[`B_TEMP] = fault_q[`B_TEMP] | fault_in.temp;
      if (step) begin
         pos_d = ccw ? pos_q - 29'h1 : pos_q + 29'h1;
      end
      unique case (mode_q)
         ST_PWRON: begin
            // direction level at the end of power-on is the reference
            dir_ref_d = dflt_q;
            if (tmr_q >= 28'(PWRON_CYC - 1)) begin
               mode_d = ST_RUN;
               tmr_d = 28'h0;
            end else begin
               tmr_d = tmr_q + 28'h1;
            end
         end
         ST_RUN: begin
            if (dflt_q != dir_ref_q) begin
               fault_d[`B_DIRCHG] = 1'b1;
            end
            if (prise) begin
               pos_d = cfg_q[`B_PRESET_EN] ? preset_val_q : 29'h0;
               mode_d = ST_PROC;
               tmr_d = 28'h0;
            end
         end
         ST_PROC: begin
            if (dflt_q != dir_ref_q) begin
               fault_d[`B_DIRCHG] = 1'b1;
            end
            if (tmr_q >= 28'(PROC_CYC - 1)) begin
               mode_d = ST_RUN;
               tmr_d = 28'h0;
            end else begin
               tmr_d = tmr_q + 28'h1;
            end
         end
      endcase
   end

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   // one-hot select shared by write and read paths so they never disagree
   function automatic logic [4:0] reg_sel(input logic [11:0] a);
      logic [4:0] sel;
      sel = 5'h00;
      unique case (a)
         `A_CTRL: sel[`R_CTRL] = 1'b1;
         `A_FAULT: sel[`R_FAULT] = 1'b1;
         `A_STATE: sel[`R_STATE] = 1'b1;
         `A_POS: sel[`R_POS] = 1'b1;
         `A_PRESET: sel[`R_PRESET] = 1'b1;
         default: sel = 5'h00;
      endcase
      return sel;
   endfunction

   // ----------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------
   logic wr, rd;
   logic [4:0] wsel, rsel;
   logic [31:0] rdata_d;
   logic [31:0] prdata_q;
   assign wr = psel & penable & pwrite;
   // read data caught at setup so it stands through the access phase
   assign rd = psel & ~penable & ~pwrite;
   assign wsel = wr ? reg_sel(paddr) : 5'h00;
   assign rsel = rd ? reg_sel(paddr) : 5'h00;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;

   always_comb begin
      cfg_d = cfg_q;
      preset_val_d = preset_val_q;
      // writes to read-only or unmapped words are dropped quietly
      if (wsel[`R_CTRL]) begin
         cfg_d = pwdata[1:0];
      end
      if (wsel[`R_PRESET]) begin
         preset_val_d = pwdata[28:0];
      end
      rdata_d = prdata_q;
      if (rd) begin
         rdata_d = 32'h0;
         if (rsel[`R_CTRL]) begin
            rdata_d = {30'h0, cfg_q};
         end
         if (rsel[`R_FAULT]) begin
            rdata_d = {27'h0, fault_q};
         end
         if (rsel[`R_STATE]) begin
            rdata_d = {28'h0, dflt_q, pflt_q, mode_q};
         end
         // withheld while not valid
         if (rsel[`R_POS] && stat_out.pos_valid) begin
            rdata_d = {3'h0, pos_q};
         end
         if (rsel[`R_PRESET]) begin
            rdata_d = {3'h0, preset_val_q};
         end
      end
   end

   // ----------------------------------------
   // status pin and LED
   // ----------------------------------------
   stat_out_t stat_d;
   logic alarm;
   // led and pin share one alarm term so they cannot disagree
   assign alarm = (|fault_d) | (mode_d == ST_PROC);
   always_comb begin
      stat_d = '0;
      // open collector: only ever pulled low, the pull-up gives the high
      stat_d.status_o = 1'b0;
      stat_d.status_oe = alarm;
      stat_d.led_on = alarm;
      stat_d.pos_valid = mode_d == ST_RUN;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt_q <= 25'h0;
         pflt_q <= 1'b0;
         dcnt_q <= 25'h0;
         dflt_q <= 1'b0;
      end else begin
         pcnt_q <= pcnt_d;
         pflt_q <= pflt_d;
         dcnt_q <= dcnt_d;
         dflt_q <= dflt_d;
      end
   end

   // power-on reset is the only way out of a latched fault
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= ST_PWRON;
         tmr_q <= 28'h0;
         pos_q <= 29'h0;
         fault_q <= 5'h0;
         dir_ref_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         tmr_q <= tmr_d;
         pos_q <= pos_d;
         fault_q <= fault_d;
         dir_ref_q <= dir_ref_d;
      end
   end

   // configuration lasts only until the next reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preset_val_q <= 29'h0;
         cfg_q <= 2'h0;
         prdata_q <= 32'h0;
      end else begin
         preset_val_q <= preset_val_d;
         cfg_q <= cfg_d;
         prdata_q <= rdata_d;
      end
   end

   // outputs straight from flops so the pin never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_out <= '0;
      end else begin
         stat_out <= stat_d;
      end
   end
endmodule

// ===== enc_chk.sv
`timescale 1ns/1ns
module enc_chk #(
   parameter int PWRON_CYC = 20,
   parameter int PROC_CYC = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic preset_pin,
   input wire logic preset_key,
   input wire logic dir_pin,
   input wire enc_pkg::fault_in_t fault_in,
   input wire enc_pkg::stat_out_t stat_out
);
   import enc_pkg::*;
   int lo_q;
   int lo_d;
   always_comb lo_d = stat_out.pos_valid ? 0 : lo_q + 1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_q <= 0;
      else lo_q <= lo_d;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_drop;
      $fell(stat_out.pos_valid);
   endsequence
   sequence s_alarm_held;
      stat_out.led_on [*6];
   endsequence
   a_led_tracks_status: assert property (stat_out.led_on == stat_out.status_oe)
      else $error("led and status disagree");
   a_status_open: assert property (stat_out.status_o == 1'b0)
      else $error("status pin driven high");
   a_low_capped: assert property (lo_q <= PWRON_CYC + 4)
      else $error("position invalid too long");
   a_proc_min: assert property ($rose(stat_out.pos_valid) |-> lo_q >= PROC_CYC - 1)
      else $error("processing ended early");
   a_proc_alarm: assert property (s_drop |-> ##1 s_alarm_held)
      else $error("no alarm while processing");
   a_fault_raise: assert property (fault_in != 4'h0 |-> ##[1:4] stat_out.led_on)
      else $error("fault not shown");
   a_fault_sticky: assert property (fault_in != 4'h0 ##4 1'b1 |-> stat_out.led_on [*8])
      else $error("fault indication cleared");
   a_no_glitch: assert property ((stat_out.pos_valid && !preset_pin && !preset_key) [*8]
      |=> stat_out.pos_valid)
      else $error("preset without input");
   a_preset_delay: assert property ($rose(preset_pin) && stat_out.pos_valid
      |-> stat_out.pos_valid [*3])
      else $error("preset acted on too soon");
   a_dir_alarm: assert property ($changed(dir_pin) && stat_out.pos_valid
      |-> ##[1:12] stat_out.led_on)
      else $error("direction change not flagged");
endmodule
bind encoder_preset_dir_status enc_chk #(.PWRON_CYC(PWRON_CYC), .PROC_CYC(PROC_CYC)) i_enc_chk (
   .pclk(pclk), .presetn(presetn), .preset_pin(preset_pin), .preset_key(preset_key),
   .dir_pin(dir_pin), .fault_in(fault_in), .stat_out(stat_out));

// ===== ctrl_model.sv
`timescale 1ns/1ns
module ctrl_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [7:0] hold,
   input wire logic use_key,
   output logic preset_pin,
   output logic preset_key
);
   logic [7:0] left_q = 8'h00;
   // a hold shorter than the filter is asked for on purpose by one test
   always @(posedge pclk) begin
      if (go) left_q <= hold;
      else if (left_q != 8'h00) left_q <= left_q - 8'h01;
   end
   assign preset_pin = (left_q != 8'h00) && !use_key;
   assign preset_key = (left_q != 8'h00) && use_key;
endmodule

// ===== encoder_preset_dir_status_test.sv
`timescale 1ns/1ns
`include "enc_defs.svh"
module encoder_preset_dir_status_test;
   import enc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dir_pin, step, go, use_key;
   logic preset_pin, preset_key;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] hold;
   fault_in_t fault_in;
   stat_out_t stat_out;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   encoder_preset_dir_status #(.PWRON_CYC(20), .PROC_CYC(10), .PRE_CYC(4), .DIR_CYC(4))
      i_encoder_preset_dir_status (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .preset_pin, .preset_key, .dir_pin, .step, .fault_in,
      .stat_out);
   ctrl_model i_ctrl_model (.pclk, .go, .hold, .use_key, .preset_pin, .preset_key);
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end
   task conclude;
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // ----
   // bus and pin helpers, all entered just after an edge
   // ----
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task stchk(input logic [3:0] exp);
      chk({28'h0, stat_out}, {28'h0, exp});
   endtask
   task wait_valid;
      for (int i = 0; i < 100 && stat_out.pos_valid !== 1'b1; i++) @(posedge pclk);
   endtask
   task press(input logic k, input logic [7:0] h);
      use_key <= k; hold <= h; go <= 1;
      @(posedge pclk); go <= 0;
      repeat (12) @(posedge pclk);
   endtask
   task rst(input logic d);
      presetn <= 0; dir_pin <= d;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, step, go, use_key, presetn, dir_pin} = 8'h00;
      paddr = 12'h000; pwdata = 32'h0; hold = 8'h00; fault_in = '0;
      @(posedge pclk);
      rst(1'b0);
      stchk(4'h0);
      wait_valid();
      stchk(4'h1);
      rdchk(`A_STATE, 32'h1);
      step <= 1; repeat (3) @(posedge pclk); step <= 0;
      rdchk(`A_POS, 32'h3);
      press(1'b0, 8'h0C);
      stchk(4'h6);
      wait_valid();
      rdchk(`A_POS, 32'h0);
      apb(1'b1, `A_PRESET, 32'h1234);
      apb(1'b1, `A_CTRL, 32'h2);
      press(1'b1, 8'h0C);
      wait_valid();
      rdchk(`A_POS, 32'h1234);
      press(1'b0, 8'h02);
      stchk(4'h1);
      rdchk(12'h0FC, 32'h0);
      for (int b = 0; b < 4; b++) begin
         fault_in <= fault_in_t'(4'h8 >> b);
         @(posedge pclk); fault_in <= '0;
         repeat (4) @(posedge pclk);
      end
      stchk(4'h7);
      rdchk(`A_FAULT, 32'hF);
      dir_pin <= 1;
      repeat (12) @(posedge pclk);
      rdchk(`A_FAULT, 32'h1F);
      rst(1'b1);
      wait_valid();
      rdchk(`A_FAULT, 32'h0);
      step <= 1; repeat (2) @(posedge pclk); step <= 0;
      rdchk(`A_POS, 32'h1FFFFFFE);
      apb(1'b1, `A_CTRL, 32'h1);
      step <= 1; repeat (2) @(posedge pclk); step <= 0;
      rdchk(`A_POS, 32'h0);
      dir_pin <= 0;
      repeat (12) @(posedge pclk);
      stchk(4'h7);
      rdchk(`A_FAULT, 32'h10);
      conclude();
   end
endmodule
